// [cst_pkg.sv]
// ****************************************************************
// channel master constants
// ****************************************************************
package cst_pkg;
    // clock period in picoseconds (250 mhz)
    localparam int CLK_PERIOD_PS = 4000;

    // bus widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // edge-to-edge times as printed, in ns
    localparam int T_ST_ADDR_NS = 10;     // status after address valid
    localparam int T_ADL_ADDR_NS = 45;    // latch strobe after address valid
    localparam int T_ADL_ST_NS = 12;      // latch strobe after status
    localparam int T_ADL_CMD_NS = 40;     // latch strobe before command
    localparam int T_CMD_ST_NS = 55;      // command after status
    localparam int T_CMD_ADDR_NS = 85;    // command after address valid
    localparam int T_CMD_WIDTH_NS = 90;   // least command width
    localparam int T_CMD_CMD_NS = 190;    // command lead to next lead
    localparam int T_CMD_GAP_NS = 80;     // command inactive between cycles
    localparam int T_ST_HOLD_NS = 30;     // status hold after command
    localparam int T_WD_HOLD_NS = 30;     // write data hold after command
    localparam int T_READY_MAX_NS = 3500; // longest ready stall

    // least time: round up, at least one cycle
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // longest time: round down, at least one cycle
    function automatic int cyc_dn(input int ns);
        int c;
        c = (ns * 1000) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // phase offsets counted from address valid
    localparam int OFS_ST = cyc_up(T_ST_ADDR_NS);
    localparam int OFS_ADL = imax(cyc_up(T_ADL_ADDR_NS), OFS_ST + cyc_up(T_ADL_ST_NS));
    localparam int OFS_CMD = imax(imax(OFS_ADL + cyc_up(T_ADL_CMD_NS),
        OFS_ST + cyc_up(T_CMD_ST_NS)), cyc_up(T_CMD_ADDR_NS));
    // phase lengths counted from command edges
    localparam int CMD_MIN = cyc_up(T_CMD_WIDTH_NS);
    localparam int GAP_CYC = imax(cyc_up(T_CMD_GAP_NS), cyc_up(T_CMD_CMD_NS) - CMD_MIN);
    localparam int ST_HOLD = cyc_up(T_ST_HOLD_NS);
    localparam int WD_HOLD = cyc_up(T_WD_HOLD_NS);
    localparam int READY_MAX = cyc_dn(T_READY_MAX_NS);

    // phase counter width
    localparam int CNT_W = 10;

    // request word layout
    localparam int REQ_DATA_LSB = 0;
    localparam int REQ_ADDR_LSB = REQ_DATA_LSB + DATA_W;
    localparam int REQ_BE_LSB = REQ_ADDR_LSB + ADDR_W;
    localparam int REQ_MEMIO_BIT = REQ_BE_LSB + BE_W;
    localparam int REQ_WRITE_BIT = REQ_MEMIO_BIT + 1;
    localparam int REQ_W = REQ_WRITE_BIT + 1;

    // status pair {one, zero}, active low
    localparam logic [1:0] STAT_IDLE = 2'h3;
    localparam logic [1:0] STAT_WRITE = 2'h2;
    localparam logic [1:0] STAT_READ = 2'h1;

    // cycle sequencer states
    typedef enum logic [1:0] {
        CST_IDLE,
        CST_ADDR,
        CST_CMD,
        CST_GAP
    } cst_state_e;
endpackage

// [cst_fifo_if.sv]
`timescale 1ns/1ps
// ****************************************************************
// request queue carrier
// ****************************************************************
interface cst_fifo_if #(
    parameter int WIDTH = 8
);
    logic push_valid; // producer has a word
    logic push_ready; // queue can take a word
    logic [WIDTH-1:0] push_data;
    logic pop_valid; // head word present
    logic pop_ready; // consumer takes head
    logic [WIDTH-1:0] pop_data;

    modport fifo_mp (
        input push_valid,
        input push_data,
        input pop_ready,
        output push_ready,
        output pop_valid,
        output pop_data
    );
    modport user_mp (
        output push_valid,
        output push_data,
        output pop_ready,
        input push_ready,
        input pop_valid,
        input pop_data
    );
endinterface

// [cst_fifo.sv]
`timescale 1ns/1ps
// ****************************************************************
// request fifo, registered head
// ****************************************************************
module cst_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    cst_fifo_if.fifo_mp f
);
    import cst_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // depth must be a power of two so pointers wrap cleanly
    if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(f.push_data) != WIDTH) begin : g_chk
        $error("cst_fifo: bad DEPTH or WIDTH");
    end

    typedef struct packed {
        logic [AW-1:0] wptr;    // next write slot
        logic [AW-1:0] rptr;    // next read slot
        logic [AW:0] count;     // words held in memory
        logic in_ready;         // room for a push
        logic out_valid;        // head register full
        logic [WIDTH-1:0] out_data;
    } cst_fifo_s;

    cst_fifo_s s_q, s_d;
    logic [WIDTH-1:0] mem [DEPTH]; // storage, not reset
    logic push;
    logic pop;
    logic load;

    // handshakes
    assign push = f.push_valid && s_q.in_ready;
    assign pop = s_q.out_valid && f.pop_ready;
    // refill head when empty or being drained
    assign load = (s_q.count != '0) && (!s_q.out_valid || pop);

    // next state
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wptr = s_q.wptr + 1'b1;
        end
        if (load) begin
            s_d.rptr = s_q.rptr + 1'b1;
            s_d.out_data = mem[s_q.rptr];
        end
        s_d.count = s_q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        // head register adds one word of slack beyond depth
        s_d.in_ready = s_d.count < (AW + 1)'(DEPTH);
        if (load) begin
            s_d.out_valid = 1'b1;
        end else if (pop) begin
            s_d.out_valid = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // memory write port
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[s_q.wptr] <= f.push_data;
        end
    end

    assign f.push_ready = s_q.in_ready;
    assign f.pop_valid = s_q.out_valid;
    assign f.pop_data = s_q.out_data;
endmodule

// [cst_master.sv]
`timescale 1ns/1ps
// Operation
// - address group valid before other signals
// - status then latch strobe after address
// - command asserts while latch strobe releases
// - hold cycle while ready return inactive
// - master ends cycle by releasing command
// - next address may overlap current command; here the next address waits until the sequencer is idle
// - command width 90, period 190, gap 80
// - strobe 40 before command, status 55
// - width returns are negative or
// - ready return is and of slaves
module cst_master #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    // request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_memio,
    input wire logic [cst_pkg::BE_W-1:0] req_be,
    input wire logic [cst_pkg::ADDR_W-1:0] req_addr,
    input wire logic [cst_pkg::DATA_W-1:0] req_wdata,
    // answer side
    output logic rsp_valid,
    output logic [cst_pkg::DATA_W-1:0] rsp_rdata,
    output logic rsp_width16,
    output logic rsp_width32,
    output logic rsp_timeout,
    output logic busy,
    // channel pins
    output logic [cst_pkg::ADDR_W-1:0] bus_addr,
    output logic address_enable_24,
    output logic memory_io,
    output logic refresh_n,
    output logic status_bit_zero,
    output logic status_bit_one,
    output logic address_decode_latch_strobe_n,
    output logic command_strobe_n,
    output logic high_byte_enable_n,
    output logic [cst_pkg::BE_W-1:0] byte_lane_enables_n,
    output logic [cst_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [cst_pkg::DATA_W-1:0] data_in,
    input wire logic width16_return_n,
    input wire logic width32_return_n,
    input wire logic ready_return
);
    import cst_pkg::*;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (READY_MAX >= (1 << CNT_W) || OFS_CMD >= (1 << CNT_W) || FIFO_DEPTH < 2) begin : g_chk
        $error("cst_master: counter too narrow or fifo too shallow");
    end

    // ****************************************************************
    // request queue
    // ****************************************************************
    cst_fifo_if #(.WIDTH(REQ_W)) fq ();

    cst_fifo #(
        .WIDTH(REQ_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .f(fq)
    );

    // pack user request into queue word
    assign fq.push_valid = req_valid;
    assign fq.push_data = {req_write, req_memio, req_be, req_addr, req_wdata};

    // ****************************************************************
    // sequencer state
    // ****************************************************************
    typedef struct packed {
        cst_state_e state;
        logic [CNT_W-1:0] cnt;      // phase counter
        logic write;                // current cycle direction
        logic [DATA_W-1:0] wdata;   // held write data
        logic [ADDR_W-1:0] addr;
        logic ae24;
        logic memio;
        logic [1:0] status;         // {one, zero}
        logic adl_n;
        logic cmd_n;
        logic high_byte_enable_n_n;
        logic [BE_W-1:0] be_n;
        logic doe;
        logic rsp_valid;
        logic [DATA_W-1:0] rdata;
        logic w16;
        logic w32;
        logic tmo;
        logic bsy;                  // sequencer not idle
    } cst_master_s;

    cst_master_s s_q, s_d;
    logic [CNT_W-1:0] cnt_inc;  // counter plus one
    logic [REQ_W-1:0] head;     // queue head word

    assign cnt_inc = s_q.cnt + 1'b1;
    assign head = fq.pop_data;
    // a new request is only taken between cycles, so no overlap
    assign fq.pop_ready = (s_q.state == CST_IDLE);

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        unique case (s_q.state)
            // idle: wait for a queued request
            CST_IDLE: begin
                if (fq.pop_valid) begin
                    // address group first, all else still idle
                    s_d.addr = head[REQ_ADDR_LSB +: ADDR_W];
                    s_d.ae24 = 1'b1;
                    s_d.memio = head[REQ_MEMIO_BIT];
                    s_d.be_n = ~head[REQ_BE_LSB +: BE_W];
                    s_d.high_byte_enable_n_n = ~head[REQ_BE_LSB + 1];
                    s_d.write = head[REQ_WRITE_BIT];
                    s_d.wdata = head[REQ_DATA_LSB +: DATA_W];
                    s_d.cnt = '0;
                    s_d.state = CST_ADDR;
                end
            end
            // address phase: status, then latch strobe, then command
            CST_ADDR: begin
                s_d.cnt = cnt_inc;
                if (cnt_inc == CNT_W'(OFS_ST)) begin
                    s_d.status = s_q.write ? STAT_WRITE : STAT_READ;
                    // write data ahead of command, zero setup needed
                    s_d.doe = s_q.write;
                end
                if (cnt_inc == CNT_W'(OFS_ADL)) begin
                    s_d.adl_n = 1'b0;
                end
                if (cnt_inc == CNT_W'(OFS_CMD)) begin
                    // command leads, latch strobe trails together
                    s_d.adl_n = 1'b1;
                    s_d.cmd_n = 1'b0;
                    s_d.cnt = '0;
                    s_d.state = CST_CMD;
                end
            end
            // command phase: least width, then wait on ready
            CST_CMD: begin
                s_d.cnt = cnt_inc;
                if (cnt_inc == CNT_W'(ST_HOLD)) begin
                    s_d.status = STAT_IDLE;
                end
                // stall while any slave holds ready low; bail out
                // after the longest legal stall so a stuck card cannot hang us
                if ((cnt_inc >= CNT_W'(CMD_MIN) && ready_return)
                    || cnt_inc == CNT_W'(READY_MAX)) begin
                    s_d.cmd_n = 1'b1;
                    s_d.status = STAT_IDLE;
                    s_d.rdata = s_q.write ? '0 : data_in;
                    s_d.w16 = ~width16_return_n;
                    s_d.w32 = ~width32_return_n;
                    s_d.tmo = !ready_return;
                    s_d.rsp_valid = 1'b1;
                    s_d.cnt = '0;
                    s_d.state = CST_GAP;
                end
            end
            // recovery: write data hold, then command gap
            CST_GAP: begin
                s_d.cnt = cnt_inc;
                if (cnt_inc == CNT_W'(WD_HOLD)) begin
                    s_d.doe = 1'b0;
                end
                if (cnt_inc == CNT_W'(GAP_CYC)) begin
                    // address group invalid, slaves drop feedback
                    s_d.ae24 = 1'b0;
                    s_d.cnt = '0;
                    s_d.state = CST_IDLE;
                end
            end
        endcase
        // busy registered so the pin comes straight from a flop
        s_d.bsy = (s_d.state != CST_IDLE);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{state: CST_IDLE, cnt: '0, write: 1'b0, wdata: '0, addr: '0,
                ae24: 1'b0, memio: 1'b0, status: STAT_IDLE, adl_n: 1'b1,
                cmd_n: 1'b1, high_byte_enable_n_n: 1'b1, be_n: '1, doe: 1'b0, rsp_valid: 1'b0,
                rdata: '0, w16: 1'b0, w32: 1'b0, tmo: 1'b0, bsy: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs from the state register, except req_ready (queue) and refresh_n (tied high)
    // ****************************************************************
    assign req_ready = fq.push_ready;
    assign rsp_valid = s_q.rsp_valid;
    assign rsp_rdata = s_q.rdata;
    assign rsp_width16 = s_q.w16;
    assign rsp_width32 = s_q.w32;
    assign rsp_timeout = s_q.tmo;
    assign busy = s_q.bsy;
    assign bus_addr = s_q.addr;
    assign address_enable_24 = s_q.ae24;
    assign memory_io = s_q.memio;
    // refresh cycles are not generated
    assign refresh_n = 1'b1;
    assign status_bit_zero = s_q.status[0];
    assign status_bit_one = s_q.status[1];
    assign address_decode_latch_strobe_n = s_q.adl_n;
    assign command_strobe_n = s_q.cmd_n;
    assign high_byte_enable_n = s_q.high_byte_enable_n_n;
    assign byte_lane_enables_n = s_q.be_n;
    assign data_out = s_q.wdata;
    assign data_oe = s_q.doe;
endmodule

// [cst_master_checker.sv]
`timescale 1ns/1ps
// ****************************************************************
// channel master protocol checker
// ****************************************************************
module cst_master_checker
import cst_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [cst_pkg::ADDR_W-1:0] bus_addr,
    input wire logic address_enable_24,
    input wire logic status_bit_zero,
    input wire logic status_bit_one,
    input wire logic address_decode_latch_strobe_n,
    input wire logic command_strobe_n,
    input wire logic rsp_valid,
    input wire logic rsp_width16,
    input wire logic width16_return_n,
    input wire logic ready_return
);
    logic [9:0] run_q; // cycles at present command level, saturating
    logic cmd_prev_q; // command level one cycle back
    logic [1:0] st; // status pair {one, zero}

    assign st = {status_bit_one, status_bit_zero};

    // run counter restarts on each command edge; saturates so idle time cannot wrap
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            run_q <= 10'h3ff;
            cmd_prev_q <= 1'b1;
        end else begin
            cmd_prev_q <= command_strobe_n;
            if (command_strobe_n != cmd_prev_q) begin
                run_q <= 10'h1;
            end else if (run_q != 10'h3ff) begin
                run_q <= run_q + 10'h1;
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    addr_before_status_a: assert property ($changed(st) && st != 2'h3 |->
        $past(address_enable_24, 3) && $stable(bus_addr)) else $error("status before address");
    status_before_latch_a: assert property ($fell(address_decode_latch_strobe_n) |->
        st != 2'h3 && $past(st, 3) != 2'h3) else $error("latch strobe before status");
    latch_lead_a: assert property ($fell(command_strobe_n) |->
        $past(address_decode_latch_strobe_n, 10) == 1'b0 && $past(st, 14) != 2'h3)
        else $error("command too early");
    cmd_release_a: assert property ($fell(command_strobe_n) |->
        $rose(address_decode_latch_strobe_n)) else $error("latch strobe not released");
    cmd_width_a: assert property ($rose(command_strobe_n) |-> run_q >= 10'd23)
        else $error("command too short");
    cmd_gap_a: assert property ($fell(command_strobe_n) |-> run_q >= 10'd20)
        else $error("command gap too short");
    ready_hold_a: assert property (!command_strobe_n && !cmd_prev_q && !ready_return
        && run_q < 10'd870 |=> !command_strobe_n) else $error("command ended while stalled");
    cmd_bound_a: assert property (!command_strobe_n && !cmd_prev_q |-> run_q < 10'd878)
        else $error("command never times out");
    addr_hold_a: assert property (!command_strobe_n |->
        address_enable_24 && $stable(bus_addr)) else $error("address moved in command");
    end_response_a: assert property ($rose(command_strobe_n) |->
        rsp_valid && rsp_width16 == !$past(width16_return_n)) else $error("bad cycle end");
    resp_cause_a: assert property (rsp_valid |-> $rose(command_strobe_n))
        else $error("response without cycle end");
endmodule

bind cst_master cst_master_checker chk_u (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bus_addr(bus_addr),
    .address_enable_24(address_enable_24),
    .status_bit_zero(status_bit_zero),
    .status_bit_one(status_bit_one),
    .address_decode_latch_strobe_n(address_decode_latch_strobe_n),
    .command_strobe_n(command_strobe_n),
    .rsp_valid(rsp_valid),
    .rsp_width16(rsp_width16),
    .width16_return_n(width16_return_n),
    .ready_return(ready_return)
);

// [cst_slave_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// slave card model, single card so returns equal card lines
// ****************************************************************
module cst_slave_model
import cst_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [1:0] mode, // 0 default, 1 sync ext, 2 async ext, 3 stuck
    input wire logic [1:0] cap, // bit0 16-bit, bit1 32-bit
    input wire logic [7:0] stall_len,
    input wire logic [cst_pkg::ADDR_W-1:0] bus_addr,
    input wire logic address_enable_24,
    input wire logic memory_io,
    input wire logic status_bit_zero,
    input wire logic status_bit_one,
    input wire logic address_decode_latch_strobe_n,
    input wire logic command_strobe_n,
    input wire logic [cst_pkg::DATA_W-1:0] data_out,
    output logic [cst_pkg::DATA_W-1:0] data_in,
    output logic width16_return_n,
    output logic width32_return_n,
    output logic ready_return
);
    logic [DATA_W-1:0] mem_q [16];
    logic [DATA_W-1:0] junk_q; // churns so a released bus never looks valid
    logic [7:0] cnt_q;
    logic sel, st_act, rd_q, wr_q, stall_q, done_q, adl_prev_q, cmd_prev_q;
    logic card_selected_feedback_n;

    // unlatched decode: memory space, top nibble 5
    assign sel = address_enable_24 && memory_io && bus_addr[23:20] == 4'h5;
    assign st_act = {status_bit_one, status_bit_zero} != STAT_IDLE;
    assign card_selected_feedback_n = !sel;
    assign width16_return_n = !(sel && cap[0]);
    assign width32_return_n = !(sel && cap[1]);
    assign ready_return = !stall_q;
    assign data_in = (sel && rd_q && !command_strobe_n && !stall_q) ?
        mem_q[bus_addr[5:2]] : junk_q;

    // ****************************************************************
    // cycle tracking and stall timing
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 16; i++) begin
                mem_q[i] <= '0;
            end
            junk_q <= 32'h5a5a0f0f;
            {cnt_q, rd_q, wr_q, stall_q, done_q} <= '0;
            {adl_prev_q, cmd_prev_q} <= 2'h3;
        end else begin
            junk_q <= ~junk_q + 32'h1;
            adl_prev_q <= address_decode_latch_strobe_n;
            cmd_prev_q <= command_strobe_n;
            // cycle kind taken at latch strobe fall
            if (adl_prev_q && !address_decode_latch_strobe_n) begin
                rd_q <= {status_bit_one, status_bit_zero} == STAT_READ;
                wr_q <= {status_bit_one, status_bit_zero} == STAT_WRITE;
            end
            if (sel && wr_q && !command_strobe_n) begin
                mem_q[bus_addr[5:2]] <= data_out;
            end
            if (!stall_q) begin
                cnt_q <= 8'h0;
                if (sel && mode != 2'h0 && st_act && !done_q) begin
                    stall_q <= 1'b1;
                end
            end else begin
                // sync mode counts from the command lead only
                if (!(mode == 2'h1 && command_strobe_n)) begin
                    cnt_q <= cnt_q + 8'h1;
                end
                if (mode != 2'h3 && cnt_q == (mode == 2'h1 ? 8'h5 : stall_len)) begin
                    stall_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
            // command end closes the cycle, even a stuck one
            if (!cmd_prev_q && command_strobe_n) begin
                done_q <= 1'b0;
                stall_q <= 1'b0;
            end
        end
    end
endmodule

// [channel_slave_transfer_cycle_tb_top.sv]
`timescale 1ns/1ps
module channel_slave_transfer_cycle_tb_top;
    import cst_pkg::*;
    typedef struct packed {logic [31:0] rd; logic chk; logic w16; logic w32; logic to;
        logic [3:0] be; logic w;} cst_exp_s;
    logic ref_clk, resetn, req_valid, req_ready, req_write, req_memio, rsp_valid, busy;
    logic rsp_width16, rsp_width32, rsp_timeout, address_enable_24, memory_io, refresh_n;
    logic status_bit_zero, status_bit_one, address_decode_latch_strobe_n, command_strobe_n;
    logic high_byte_enable_n, data_oe, width16_return_n, width32_return_n, ready_return;
    logic [3:0] req_be, byte_lane_enables_n;
    logic [23:0] req_addr, bus_addr;
    logic [31:0] req_wdata, rsp_rdata, data_out, data_in;
    logic [1:0] mode, cap;
    logic [7:0] stall_len;
    logic [1:0] caps [3] = '{2'h0, 2'h1, 2'h3};
    logic [31:0] shadow [16];
    cst_exp_s exp_q[$];
    cst_exp_s mon_e;
    int miscompares, comparisons, n;
    logic waited;

    cst_master #(.FIFO_DEPTH(16)) dut_u (.*);
    cst_slave_model slave_u (.*);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // checking helpers
    // ****************************************************************
    task automatic stop_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // expected answer of one request, from card decode and shadow memory
    function automatic cst_exp_s expect_of(input logic w, input logic m, input logic [23:0] a,
        input logic [31:0] d);
        cst_exp_s e;
        logic s;
        s = m && a[23:20] == 4'h5;
        e.w16 = s && cap[0];
        e.w32 = s && cap[1];
        e.to = s && mode == 2'h3;
        e.chk = w || (s && !e.to);
        e.be = req_be;
        e.w = w;
        e.rd = w ? 32'h0 : shadow[a[5:2]];
        if (w && s) shadow[a[5:2]] = d;
        return e;
    endfunction

    // valid held until the edge that sees ready
    task automatic send(input logic w, input logic m, input logic [23:0] a, input logic [31:0] d);
        int k;
        k = 0;
        req_valid <= 1'b1;
        req_write <= w;
        req_memio <= m;
        req_addr <= a;
        req_wdata <= d;
        req_be <= 4'($urandom);
        @(posedge ref_clk);
        while (req_ready !== 1'b1) begin
            waited = 1'b1;
            k++;
            if (k > 20000) begin
                miscompares++;
                stop_test();
            end
            @(posedge ref_clk);
        end
        exp_q.push_back(expect_of(w, m, a, d));
    endtask

    task automatic drain();
        int k;
        k = 0;
        req_valid <= 1'b0;
        while (exp_q.size() != 0) begin
            k++;
            if (k > 30000) begin
                miscompares++;
                stop_test();
            end
            @(posedge ref_clk);
        end
    endtask

    // responses judged at the falling edge, when settled
    always @(negedge ref_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0); // response nobody asked for
            end else begin
                mon_e = exp_q.pop_front();
                if (mon_e.chk) begin
                    check(rsp_rdata, mon_e.rd);
                end
                check(32'({rsp_width16, rsp_width32, rsp_timeout}), 32'({mon_e.w16, mon_e.w32, mon_e.to}));
                check(32'({busy, data_oe, refresh_n, high_byte_enable_n}),
                    32'({1'b1, mon_e.w, 1'b1, !mon_e.be[1]}));
                check({28'h0, byte_lane_enables_n}, {28'h0, ~mon_e.be});
            end
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {resetn, req_valid, req_write, req_memio, req_be, req_addr, req_wdata} = '0;
        {mode, stall_len, miscompares, comparisons, waited} = '0;
        cap = 2'h3;
        for (int i = 0; i < 16; i++) shadow[i] = 32'h0;
        void'($urandom(40));
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        // each cycle kind with its own card width, random traffic
        for (int k = 0; k < 3; k++) begin
            mode <= 2'(k);
            cap <= caps[k];
            stall_len <= 8'(20 + $urandom_range(180));
            @(posedge ref_clk);
            for (int i = 0; i < 12; i++) begin
                send(i < 4 || $urandom_range(1), $urandom_range(3) != 0,
                    {($urandom_range(2) != 0) ? 4'h5 : 4'h3, 18'($urandom), 2'h0}, $urandom);
            end
            drain();
        end
        // slow card while queue fills until it refuses
        mode <= 2'h2;
        cap <= 2'h1;
        stall_len <= 8'd60;
        waited = 1'b0;
        n = 0;
        @(posedge ref_clk);
        while (!waited && n < 40) begin
            send(1'b1, 1'b1, {4'h5, 18'(n), 2'h0}, $urandom);
            n++;
        end
        check(32'(n > 16), 32'h1);
        for (int i = 0; i < 16; i++) send(1'b0, 1'b1, {4'h5, 18'(i), 2'h0}, 32'h0);
        drain();
        // stuck card: cycle must end by timeout, then recover
        mode <= 2'h3;
        @(posedge ref_clk);
        send(1'b0, 1'b1, 24'h500010, 32'h0);
        send(1'b0, 1'b1, 24'h300010, 32'h0);
        drain();
        stop_test();
    end
endmodule
